// [pll_config_lock_control.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
// Overview of operation
// - Loop-off ignored while VCO selected; VCO select ignored while loop off.
// - Prescaler field, two bits, reset clear, write-blocked while loop on.
// - VCO power-of-two range field, reset clear, write-blocked while loop on.
// - Bandwidth mode bit: 1 automatic, 0 manual, reset manual.
// - Lock bit reads lock in automatic mode, zero in manual mode.
// - Acquisition bit is status in automatic, control in manual; reset track.
// - Manual acquisition value is kept and restored when manual resumes.
// - Feedback multiplier zero acts as one; reset value 64.
// - Multiplier bytes ignore writes while loop on.
// - Upper four multiplier-high bits read zero.
// - Linear range register write-blocked while loop on; reset 64.
// - Zero linear range disables loop and forces base select clear.
// - Reference divider zero acts as one; reset one; write-blocked while on.
// - Automatic mode: flag sets on each lock change; request needs enable and flag.
// - Manual mode: interrupts blocked, enable reads zero unwritable, flag reads zero.
// - A read of loop control clears the interrupt flag unless a lock change sets it in the same cycle.
// - Base clock out is half the source; switch holds output a few cycles.
module pll_config_lock_control (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic LOCK_IN,
    input wire logic TRACK_IN,
    input wire logic CRYSTAL_CLOCK,
    input wire logic VCO_CLOCK,
    output logic BASE_CLOCK_OUT,
    output logic LOOP_ENABLE,
    output logic AUTO_MODE,
    output logic ACQ_N_TRACK_OUT,
    output logic [1:0] PRESCALER_SEL,
    output logic [1:0] VCO_POW2_RANGE,
    output logic [11:0] FEEDBACK_MULTIPLIER,
    output logic [7:0] VCO_LINEAR_RANGE_BITS,
    output logic [3:0] REF_DIVIDER_BITS,
    output logic IRQ
);

    // ****************************************
    // Register state
    // ****************************************
    pll_ctl_pkg::bus_req_t req;
    logic irq_enable, next_irq_enable;
    logic irq_flag, next_irq_flag;
    logic loop_on, next_loop_on;
    logic base_sel, next_base_sel;
    logic [1:0] prescaler, next_prescaler;
    logic [1:0] pow2_range, next_pow2_range;
    logic auto_mode, next_auto_mode;
    logic acq_shadow, next_acq_shadow;
    logic lock_seen, next_lock_seen;
    logic [11:0] multiplier, next_multiplier;
    logic [7:0] linear_range, next_linear_range;
    logic [3:0] ref_div, next_ref_div;
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic lock_bit;
    logic wr_ctl;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign lock_bit = auto_mode & LOCK_IN;
    assign wr_ctl = req.wr && (req.addr == pll_ctl_pkg::ADDR_LOOP_CONTROL);

    always_comb begin
        next_irq_enable = irq_enable;
        next_irq_flag = irq_flag;
        next_loop_on = loop_on;
        next_base_sel = base_sel;
        next_prescaler = prescaler;
        next_pow2_range = pow2_range;
        next_auto_mode = auto_mode;
        next_acq_shadow = acq_shadow;
        next_multiplier = multiplier;
        next_linear_range = linear_range;
        next_ref_div = ref_div;
        next_lock_seen = lock_bit;
        next_rdata = 8'h00;
        if (req.wr) begin
            case (req.addr)
                pll_ctl_pkg::ADDR_LOOP_CONTROL: begin
                    if (auto_mode) begin
                        next_irq_enable = req.wdata[pll_ctl_pkg::BIT_IRQ_ENABLE];
                    end
                    // Loop-off refused while VCO is selected
                    if (!(base_sel && !req.wdata[pll_ctl_pkg::BIT_LOOP_ON])) begin
                        next_loop_on = req.wdata[pll_ctl_pkg::BIT_LOOP_ON];
                    end
                    // Select uses the stored loop state, so two writes are needed
                    if (req.wdata[pll_ctl_pkg::BIT_BASE_SEL]) begin
                        if (loop_on && (linear_range != 8'h00)) begin
                            next_base_sel = 1'b1;
                        end
                    end else begin
                        next_base_sel = 1'b0;
                    end
                    if (!loop_on) begin
                        next_prescaler = req.wdata[pll_ctl_pkg::BIT_PRE_LO +: 2];
                        next_pow2_range = req.wdata[pll_ctl_pkg::BIT_VPR_LO +: 2];
                    end
                end
                pll_ctl_pkg::ADDR_BANDWIDTH_CONTROL: begin
                    next_auto_mode = req.wdata[pll_ctl_pkg::BIT_AUTO];
                    if (!auto_mode) begin
                        next_acq_shadow = req.wdata[pll_ctl_pkg::BIT_ACQ];
                    end
                end
                pll_ctl_pkg::ADDR_MULTIPLIER_HIGH: begin
                    if (!loop_on) begin
                        next_multiplier[11:8] = req.wdata[3:0];
                    end
                end
                pll_ctl_pkg::ADDR_MULTIPLIER_LOW: begin
                    if (!loop_on) begin
                        next_multiplier[7:0] = req.wdata;
                    end
                end
                pll_ctl_pkg::ADDR_VCO_LINEAR_RANGE: begin
                    if (!loop_on) begin
                        next_linear_range = req.wdata;
                    end
                end
                pll_ctl_pkg::ADDR_REFERENCE_DIVIDER: begin
                    if (!loop_on) begin
                        next_ref_div = req.wdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (linear_range == 8'h00) begin
            next_base_sel = 1'b0;
        end
        if (!auto_mode) begin
            next_irq_enable = 1'b0;
        end
        // Read clears, a lock change sets and wins over the clear
        if (req.rd && (req.addr == pll_ctl_pkg::ADDR_LOOP_CONTROL)) begin
            next_irq_flag = 1'b0;
        end
        if (auto_mode && (lock_bit != lock_seen)) begin
            next_irq_flag = 1'b1;
        end
        if (!auto_mode) begin
            next_irq_flag = 1'b0;
        end
        if (req.rd) begin
            case (req.addr)
                pll_ctl_pkg::ADDR_LOOP_CONTROL: begin
                    next_rdata = {irq_enable, irq_flag & auto_mode, loop_on, base_sel,
                                  prescaler, pow2_range};
                end
                pll_ctl_pkg::ADDR_BANDWIDTH_CONTROL: begin
                    next_rdata = {auto_mode, lock_bit, ACQ_N_TRACK_OUT, 5'h00};
                end
                pll_ctl_pkg::ADDR_MULTIPLIER_HIGH: begin
                    next_rdata = {4'h0, multiplier[11:8]};
                end
                pll_ctl_pkg::ADDR_MULTIPLIER_LOW: begin
                    next_rdata = multiplier[7:0];
                end
                pll_ctl_pkg::ADDR_VCO_LINEAR_RANGE: begin
                    next_rdata = linear_range;
                end
                pll_ctl_pkg::ADDR_REFERENCE_DIVIDER: begin
                    next_rdata = {4'h0, ref_div};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            irq_enable <= 1'b0;
            irq_flag <= 1'b0;
            loop_on <= pll_ctl_pkg::RESET_LOOP_ON;
            base_sel <= 1'b0;
            prescaler <= 2'h0;
            pow2_range <= 2'h0;
            auto_mode <= 1'b0;
            acq_shadow <= 1'b0;
            lock_seen <= 1'b0;
            multiplier <= pll_ctl_pkg::RESET_MULTIPLIER;
            linear_range <= pll_ctl_pkg::RESET_LINEAR_RANGE;
            ref_div <= pll_ctl_pkg::RESET_REF_DIVIDER;
            rdata <= 8'h00;
        end else begin
            irq_enable <= next_irq_enable;
            irq_flag <= next_irq_flag;
            loop_on <= next_loop_on;
            base_sel <= next_base_sel;
            prescaler <= next_prescaler;
            pow2_range <= next_pow2_range;
            auto_mode <= next_auto_mode;
            acq_shadow <= next_acq_shadow;
            lock_seen <= next_lock_seen;
            multiplier <= next_multiplier;
            linear_range <= next_linear_range;
            ref_div <= next_ref_div;
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Outputs to the analog loop
    // ****************************************
    assign RDATA = rdata;
    assign LOOP_ENABLE = loop_on && (linear_range != 8'h00);
    assign AUTO_MODE = auto_mode;
    assign ACQ_N_TRACK_OUT = auto_mode ? TRACK_IN : acq_shadow;
    assign PRESCALER_SEL = prescaler;
    assign VCO_POW2_RANGE = pow2_range;
    assign FEEDBACK_MULTIPLIER = (multiplier == 12'h000) ? 12'h001 : multiplier;
    assign VCO_LINEAR_RANGE_BITS = linear_range;
    assign REF_DIVIDER_BITS = (ref_div == 4'h0) ? 4'h1 : ref_div;
    assign IRQ = irq_enable && irq_flag && auto_mode;

    // ****************************************
    // Base clock switch
    // ****************************************
    // Sources are sampled on CLOCK; the output holds while the old and then
    // the new source each give three rising edges.
    pll_ctl_pkg::switch_state_t sw_state, next_sw_state;
    logic [1:0] xs, vs, next_xs, next_vs;
    logic active_sel, next_active_sel;
    logic [1:0] edge_cnt, next_edge_cnt;
    logic base_out, next_base_out;
    logic src_rise;
    logic src_now;

    assign src_now = active_sel ? vs[0] : xs[0];
    assign src_rise = src_now & ~(active_sel ? vs[1] : xs[1]);

    always_comb begin
        next_xs = {xs[0], CRYSTAL_CLOCK};
        next_vs = {vs[0], VCO_CLOCK};
        next_sw_state = sw_state;
        next_active_sel = active_sel;
        next_edge_cnt = edge_cnt;
        next_base_out = base_out;
        case (sw_state)
            pll_ctl_pkg::SW_IDLE: begin
                if (base_sel != active_sel) begin
                    next_sw_state = pll_ctl_pkg::SW_OLD;
                    next_edge_cnt = 2'd0;
                end else if (src_rise) begin
                    next_base_out = ~base_out;
                end
            end
            pll_ctl_pkg::SW_OLD: begin
                if (src_rise) begin
                    if (edge_cnt == 2'(pll_ctl_pkg::SWITCH_SOURCE_CYCLES - 1)) begin
                        next_sw_state = pll_ctl_pkg::SW_NEW;
                        next_active_sel = ~active_sel;
                        next_edge_cnt = 2'd0;
                    end else begin
                        next_edge_cnt = edge_cnt + 2'd1;
                    end
                end
            end
            pll_ctl_pkg::SW_NEW: begin
                if (src_rise) begin
                    if (edge_cnt == 2'(pll_ctl_pkg::SWITCH_SOURCE_CYCLES - 1)) begin
                        next_sw_state = pll_ctl_pkg::SW_IDLE;
                    end else begin
                        next_edge_cnt = edge_cnt + 2'd1;
                    end
                end
            end
            default: begin
                next_sw_state = pll_ctl_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            xs <= 2'h0;
            vs <= 2'h0;
            sw_state <= pll_ctl_pkg::SW_IDLE;
            active_sel <= 1'b0;
            edge_cnt <= 2'd0;
            base_out <= 1'b0;
        end else begin
            xs <= next_xs;
            vs <= next_vs;
            sw_state <= next_sw_state;
            active_sel <= next_active_sel;
            edge_cnt <= next_edge_cnt;
            base_out <= next_base_out;
        end
    end

    assign BASE_CLOCK_OUT = base_out;

    // ****************************************
    // Checks
    // ****************************************
    property p_sel_needs_loop;
        @(posedge CLOCK) disable iff (RST) base_sel |-> loop_on;
    endproperty
    a_sel_needs_loop: assert property (p_sel_needs_loop) else $error("select without loop");

    property p_sel_needs_range;
        @(posedge CLOCK) disable iff (RST)
            (linear_range == 8'h00) |=> !base_sel;
    endproperty
    a_sel_needs_range: assert property (p_sel_needs_range) else $error("select with zero range");

    property p_pre_locked;
        @(posedge CLOCK) disable iff (RST) loop_on |=> $stable(prescaler) && $stable(pow2_range);
    endproperty
    a_pre_locked: assert property (p_pre_locked) else $error("prescaler changed while on");

    property p_mul_locked;
        @(posedge CLOCK) disable iff (RST)
            loop_on |=> $stable(multiplier) && $stable(linear_range) && $stable(ref_div);
    endproperty
    a_mul_locked: assert property (p_mul_locked) else $error("divider changed while on");

    property p_manual_irq;
        @(posedge CLOCK) disable iff (RST) !auto_mode |=> !irq_enable && !IRQ;
    endproperty
    a_manual_irq: assert property (p_manual_irq) else $error("irq in manual mode");

    property p_lock_flag;
        @(posedge CLOCK) disable iff (RST)
            (auto_mode && (lock_bit != lock_seen)) |=> irq_flag;
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock change missed");

    property p_read_clear;
        @(posedge CLOCK) disable iff (RST)
            (RD && ADDR == pll_ctl_pkg::ADDR_LOOP_CONTROL && !(lock_bit != lock_seen))
            |=> !irq_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

    property p_mulh_read;
        @(posedge CLOCK) disable iff (RST)
            (RD && ADDR == pll_ctl_pkg::ADDR_MULTIPLIER_HIGH) |=> RDATA[7:4] == 4'h0;
    endproperty
    a_mulh_read: assert property (p_mulh_read) else $error("upper bits nonzero");

    property p_lock_manual;
        @(posedge CLOCK) disable iff (RST)
            (RD && ADDR == pll_ctl_pkg::ADDR_BANDWIDTH_CONTROL && !auto_mode)
            |=> !RDATA[pll_ctl_pkg::BIT_LOCK];
    endproperty
    a_lock_manual: assert property (p_lock_manual) else $error("lock read in manual");

    property p_switch_hold;
        @(posedge CLOCK) disable iff (RST)
            (sw_state != pll_ctl_pkg::SW_IDLE) |=> $stable(BASE_CLOCK_OUT);
    endproperty
    a_switch_hold: assert property (p_switch_hold) else $error("output moved in switch");

endmodule

// [pll_config_lock_control_tb.sv]
`timescale 1ns/10ps
module pll_config_lock_control_tb;
    logic clock, rst, wr, rd, lock_in, track_in, crystal_clock, vco_clock, rd_seen;
    logic [7:0] addr, wdata, rdata, vco_linear_range_bits, ml;
    logic base_clock_out, loop_enable, auto_mode, acq_n_track_out, irq, prev_out, prev_src;
    logic [1:0] prescaler_sel, vco_pow2_range;
    logic [11:0] feedback_multiplier;
    logic [3:0] ref_divider_bits;
    logic [7:0] exp_q[$];
    string name_q[$];
    int num_errors, total_checks, xtal_cnt, vco_cnt, tog, rises;

    pll_config_lock_control uut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .LOCK_IN(lock_in), .TRACK_IN(track_in),
        .CRYSTAL_CLOCK(crystal_clock), .VCO_CLOCK(vco_clock),
        .BASE_CLOCK_OUT(base_clock_out), .LOOP_ENABLE(loop_enable), .AUTO_MODE(auto_mode),
        .ACQ_N_TRACK_OUT(acq_n_track_out), .PRESCALER_SEL(prescaler_sel),
        .VCO_POW2_RANGE(vco_pow2_range), .FEEDBACK_MULTIPLIER(feedback_multiplier),
        .VCO_LINEAR_RANGE_BITS(vco_linear_range_bits), .REF_DIVIDER_BITS(ref_divider_bits),
        .IRQ(irq));

    // ****************************************
    // Clocks and source clocks
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Source clocks stay well below half the system clock rate
    always @(posedge clock) begin
        xtal_cnt <= (xtal_cnt == 7) ? 0 : xtal_cnt + 1;
        vco_cnt <= (vco_cnt == 5) ? 0 : vco_cnt + 1;
        crystal_clock <= (xtal_cnt < 4);
        vco_clock <= (vco_cnt < 3);
    end

    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge clock) rd_seen <= rd;

    // Read data stand only in the cycle after the strobe
    always @(negedge clock) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("mismatch unexpected_read expected none seen %h", rdata);
            end else begin
                check(name_q.pop_front(), {4'h0, rdata}, {4'h0, exp_q.pop_front()});
            end
        end
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string what);
        exp_q.push_back(e);
        name_q.push_back(what);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
    endtask

    task automatic set_lock(input logic v);
        @(posedge clock);
        lock_in <= v;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        give_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        lock_in = 1'b0;
        track_in = 1'b0;
        crystal_clock = 1'b0;
        vco_clock = 1'b0;
        rd_seen = 1'b0;
        xtal_cnt = 0;
        vco_cnt = 0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(32'h53D7F249));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd_reg(8'h36, 8'h20, "loop_control");
        rd_reg(8'h37, 8'h00, "bandwidth_control");
        rd_reg(8'h38, 8'h00, "multiplier_high");
        rd_reg(8'h39, 8'h40, "multiplier_low");
        rd_reg(8'h3A, 8'h40, "vco_linear_range");
        rd_reg(8'h3B, 8'h01, "reference_divider");
        rd_reg(8'h40, 8'h00, "unmapped");
        @(negedge clock);
        check("feedback_multiplier", feedback_multiplier, 12'h040);
        check("vco_linear_range_bits", {4'h0, vco_linear_range_bits}, 12'h040);
        check("ref_divider_bits", {8'h00, ref_divider_bits}, 12'h001);
        // Protected fields while the loop runs; select still writable
        wr_reg(8'h36, 8'h3F);
        rd_reg(8'h36, 8'h30, "loop_control");
        wr_reg(8'h36, 8'h00);
        rd_reg(8'h36, 8'h20, "loop_control");
        wr_reg(8'h38, 8'h0F);
        wr_reg(8'h39, 8'h00);
        wr_reg(8'h3A, 8'h00);
        wr_reg(8'h3B, 8'h00);
        rd_reg(8'h38, 8'h00, "multiplier_high");
        rd_reg(8'h39, 8'h40, "multiplier_low");
        rd_reg(8'h3A, 8'h40, "vco_linear_range");
        rd_reg(8'h3B, 8'h01, "reference_divider");
        // Loop off: select refused, protected fields open
        wr_reg(8'h36, 8'h00);
        wr_reg(8'h36, 8'h10);
        rd_reg(8'h36, 8'h00, "loop_control");
        wr_reg(8'h38, 8'hFF);
        rd_reg(8'h38, 8'h0F, "multiplier_high");
        wr_reg(8'h38, 8'h00);
        wr_reg(8'h39, 8'h00);
        wr_reg(8'h3B, 8'h00);
        @(negedge clock);
        check("feedback_multiplier", feedback_multiplier, 12'h001);
        check("ref_divider_bits", {8'h00, ref_divider_bits}, 12'h001);
        wr_reg(8'h3B, 8'h05);
        rd_reg(8'h3B, 8'h05, "reference_divider");
        wr_reg(8'h3B, 8'h01);
        for (int i = 0; i < 4; i++) begin
            ml = $urandom;
            wr_reg(8'h36, {4'h0, 2'(i), 2'(i % 3)});
            wr_reg(8'h39, ml);
            rd_reg(8'h36, {4'h0, 2'(i), 2'(i % 3)}, "loop_control");
            rd_reg(8'h39, ml, "multiplier_low");
            check("prescaler_sel", {10'h0, prescaler_sel}, 12'(i));
            check("vco_pow2_range", {10'h0, vco_pow2_range}, 12'(i % 3));
            check("feedback_multiplier", feedback_multiplier, (ml == 0) ? 12'h001 : {4'h0, ml});
        end
        // Zero linear range gates the loop and the select
        wr_reg(8'h36, 8'h00);
        wr_reg(8'h3A, 8'h00);
        wr_reg(8'h37, 8'h00);
        wr_reg(8'h36, 8'h20);
        wr_reg(8'h36, 8'h30);
        rd_reg(8'h36, 8'h20, "loop_control");
        check("loop_enable", {11'h0, loop_enable}, 12'h000);
        wr_reg(8'h36, 8'h00);
        wr_reg(8'h3A, 8'h40);
        wr_reg(8'h36, 8'h20);
        wr_reg(8'h36, 8'h30);
        rd_reg(8'h36, 8'h30, "loop_control");
        check("loop_enable", {11'h0, loop_enable}, 12'h001);
        wr_reg(8'h36, 8'h20);
        // Manual mode: no flag, no enable, lock reads zero
        wr_reg(8'h37, 8'h20);
        wr_reg(8'h36, 8'hA0);
        set_lock(1'b1);
        rd_reg(8'h37, 8'h20, "bandwidth_control");
        rd_reg(8'h36, 8'h20, "loop_control");
        check("irq", {11'h0, irq}, 12'h000);
        check("acq_n_track_out", {11'h0, acq_n_track_out}, 12'h001);
        set_lock(1'b0);
        // Automatic mode: status bits follow the loop
        wr_reg(8'h37, 8'hA0);
        wr_reg(8'h37, 8'h80);
        rd_reg(8'h37, 8'h80, "bandwidth_control");
        @(negedge clock);
        check("auto_mode", {11'h0, auto_mode}, 12'h001);
        check("acq_n_track_out", {11'h0, acq_n_track_out}, 12'h000);
        @(posedge clock);
        track_in <= 1'b1;
        set_lock(1'b1);
        check("irq", {11'h0, irq}, 12'h000);
        rd_reg(8'h37, 8'hE0, "bandwidth_control");
        rd_reg(8'h36, 8'h60, "loop_control");
        rd_reg(8'h36, 8'h20, "loop_control");
        wr_reg(8'h36, 8'hA0);
        set_lock(1'b0);
        check("irq", {11'h0, irq}, 12'h001);
        rd_reg(8'h36, 8'hE0, "loop_control");
        @(negedge clock);
        check("irq", {11'h0, irq}, 12'h000);
        // Back to manual with a zero write: the kept value must return
        wr_reg(8'h37, 8'h00);
        rd_reg(8'h37, 8'h20, "bandwidth_control");
        rd_reg(8'h36, 8'h20, "loop_control");
        // Output toggles once per rise of the selected source
        for (int s = 0; s < 2; s++) begin
            wr_reg(8'h36, (s == 1) ? 8'h30 : 8'h20);
            repeat (60) @(posedge clock);
            tog = 0;
            rises = 0;
            @(negedge clock);
            prev_out = base_clock_out;
            prev_src = (s == 1) ? vco_clock : crystal_clock;
            repeat (160) begin
                @(negedge clock);
                if (base_clock_out !== prev_out) tog++;
                if (((s == 1) ? vco_clock : crystal_clock) && !prev_src) rises++;
                prev_out = base_clock_out;
                prev_src = (s == 1) ? vco_clock : crystal_clock;
            end
            check("base_clock_out_toggles", 12'((tog - rises <= 1) && (rises - tog <= 1)), 12'h001);
        end
        wr_reg(8'h36, 8'h20);
        repeat (4) @(posedge clock);
        give_verdict();
    end
endmodule

// [pll_ctl_pkg.sv]
package pll_ctl_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_LOOP_CONTROL = 8'h36;
    localparam logic [7:0] ADDR_BANDWIDTH_CONTROL = 8'h37;
    localparam logic [7:0] ADDR_MULTIPLIER_HIGH = 8'h38;
    localparam logic [7:0] ADDR_MULTIPLIER_LOW = 8'h39;
    localparam logic [7:0] ADDR_VCO_LINEAR_RANGE = 8'h3A;
    localparam logic [7:0] ADDR_REFERENCE_DIVIDER = 8'h3B;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_IRQ_ENABLE = 7;
    localparam int BIT_IRQ_FLAG = 6;
    localparam int BIT_LOOP_ON = 5;
    localparam int BIT_BASE_SEL = 4;
    localparam int BIT_PRE_LO = 2;
    localparam int BIT_VPR_LO = 0;
    localparam int BIT_AUTO = 7;
    localparam int BIT_LOCK = 6;
    localparam int BIT_ACQ = 5;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [11:0] RESET_MULTIPLIER = 12'h040;
    localparam logic [7:0] RESET_LINEAR_RANGE = 8'h40;
    localparam logic [3:0] RESET_REF_DIVIDER = 4'h1;
    localparam logic RESET_LOOP_ON = 1'b1;

    // ****************************************
    // Timing of the clock switch
    // ****************************************
    localparam int SWITCH_SOURCE_CYCLES = 3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_OLD = 2'b01,
        SW_NEW = 2'b10
    } switch_state_t;

endpackage
